// ### hw/bmd_base_mismatch_diag.v
// Base slot mismatch supervisor, status display and diagnostic frame builder
//
// Function
// - Ignore off, configured module removed: offline, display 2, outputs per jumper.
// - Ignore off, module added in unconfigured slot: ignored, display 0.
// - Ignore off, wrong module type in configured slot: display a, offline, jumper.
// - Ignore on, module added to empty slot: ignored, display 0 with point.
// - Ignore on, removed or wrong type: display 2 with point, slot excluded.
// - Fieldbus stopped: display 3, jumper output policy, inputs forced off.
// - Device in wrong base position shows display code b.
// - Diagnostic read returns exactly 15 bytes, bit 7 most significant.
// - Byte 1 holds the station status one flags.
// - Byte 2: bit7 zero, sync, freeze, bit2 one, bit1 zero, await param.
// - Byte 3 bit 7 zero, other bits reserved.
// - Byte 4 is parameterizing master address, or 255 if none.
// - Bytes 5 and 6 carry the fixed 16-bit identification code.
// - Byte 7 is device diagnostic header 0x06.
// - Byte 8 bit 0 remote port request pending; bytes 9, 10 reserved.
// - Bytes 11, 12 are type-mismatch bitmap for slots 1..16.
// - Byte 13 is identifier diagnostic header 0x43.
// - Bytes 14, 15 flag failed or mismatched slots 1..16.
// - Missing jumper behaves as the off setting.
// - Ignore on updates matching slots only; off, any mismatch stops all.
//
// The register addresses and the strobed register port were chosen for this implementation.
`default_nettype none
`include "bmd_defs.vh"

module bmd_base_mismatch_diag #(
    parameter SLOTS = 16,
    parameter [15:0] IDENT = `BMD_IDENT_DEFAULT
) (
    input wire ref_clk,
    input wire rst,
    input wire [3:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [15:0] regRdData,
    input wire [SLOTS-1:0] slotFitted,
    input wire [SLOTS-1:0] slotTypeOk,
    input wire [SLOTS-1:0] slotFailed,
    input wire commLossOutputJumperFitted,
    input wire commLossOutputJumperFreeze,
    input wire diagReadReq,
    output reg diagValid,
    output reg [7:0] diagByte,
    output reg diagLast,
    output reg [3:0] displayCode,
    output reg displayPoint,
    output reg online,
    output reg outputsFreeze,
    output reg outputsOff,
    output reg inputsForcedOff,
    output reg [SLOTS-1:0] slotUpdateEnable,
    output reg diagChanged
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [SLOTS-1:0] fitMeta, fitSync, typeMeta, typeSync, failMeta, failSync;
    reg [1:0] jumpMeta, jumpSync;
    reg readMeta, readSync, readSyncD;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fitMeta <= {SLOTS{1'b0}};
            fitSync <= {SLOTS{1'b0}};
            typeMeta <= {SLOTS{1'b0}};
            typeSync <= {SLOTS{1'b0}};
            failMeta <= {SLOTS{1'b0}};
            failSync <= {SLOTS{1'b0}};
            jumpMeta <= 2'h0;
            jumpSync <= 2'h0;
            readMeta <= 1'b0;
            readSync <= 1'b0;
            readSyncD <= 1'b0;
        end
        else
        begin
            fitMeta <= slotFitted;
            fitSync <= fitMeta;
            typeMeta <= slotTypeOk;
            typeSync <= typeMeta;
            failMeta <= slotFailed;
            failSync <= failMeta;
            jumpMeta <= {commLossOutputJumperFitted, commLossOutputJumperFreeze};
            jumpSync <= jumpMeta;
            readMeta <= diagReadReq;
            readSync <= readMeta;
            readSyncD <= readSync;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [15:0] ctrl;
    reg [SLOTS-1:0] expected;
    reg [7:0] masterAddr;
    reg [3:0] diagIdx;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `BMD_CTRL_RESET;
            expected <= {SLOTS{1'b0}};
            masterAddr <= `BMD_NO_MASTER;
            diagIdx <= 4'h0;
        end
        else if (regWrite)
        begin
            case (regAddr)
                `BMD_REG_CTRL: ctrl <= regWrData;
                `BMD_REG_EXPECT: expected <= regWrData[SLOTS-1:0];
                `BMD_REG_MASTER: masterAddr <= regWrData[7:0];
                `BMD_REG_DIAG_IDX: diagIdx <= regWrData[3:0];
                default: ;
            endcase
        end
    end

    wire ignoreOn = ctrl[`BMD_CTRL_IGNORE];
    wire busRun = ctrl[`BMD_CTRL_RUN];
    wire wrongPos = ctrl[`BMD_CTRL_WRONG_POS];

    // ----------------------------------------------------------------
    // Slot comparison
    // ----------------------------------------------------------------
    // Added modules in unconfigured slots never count as mismatch
    wire [SLOTS-1:0] removed = expected & ~fitSync;
    wire [SLOTS-1:0] wrongType = expected & fitSync & ~typeSync;
    wire [SLOTS-1:0] added = ~expected & fitSync;
    wire [SLOTS-1:0] badSlot = removed | wrongType;
    wire anyBad = |badSlot;
    wire goOffline = (!ignoreOn && anyBad) || !busRun || wrongPos;
    // Missing jumper acts as the off setting
    wire jumperFreeze = jumpSync[1] & jumpSync[0];

    reg [3:0] next_displayCode;
    reg next_displayPoint;

    always @*
    begin
        next_displayCode = `BMD_DISP_OK;
        next_displayPoint = 1'b0;
        if (wrongPos)
            next_displayCode = `BMD_DISP_WRONG_POS;
        else if (!busRun)
            next_displayCode = `BMD_DISP_STOPPED;
        else if (!ignoreOn && |removed)
            next_displayCode = `BMD_DISP_REMOVED;
        else if (!ignoreOn && |wrongType)
            next_displayCode = `BMD_DISP_WRONG_TYPE;
        else if (ignoreOn && anyBad)
        begin
            next_displayCode = `BMD_DISP_REMOVED;
            next_displayPoint = 1'b1;
        end
        else if (ignoreOn && |added)
            next_displayPoint = 1'b1;
    end

    reg [SLOTS-1:0] mismatchMap, faultMap;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            displayCode <= `BMD_DISP_STOPPED;
            displayPoint <= 1'b0;
            online <= 1'b0;
            outputsFreeze <= 1'b0;
            outputsOff <= 1'b1;
            inputsForcedOff <= 1'b1;
            slotUpdateEnable <= {SLOTS{1'b0}};
            mismatchMap <= {SLOTS{1'b0}};
            faultMap <= {SLOTS{1'b0}};
            diagChanged <= 1'b0;
        end
        else
        begin
            displayCode <= next_displayCode;
            displayPoint <= next_displayPoint;
            online <= !goOffline;
            outputsFreeze <= goOffline && jumperFreeze;
            outputsOff <= goOffline && !jumperFreeze;
            inputsForcedOff <= !busRun;
            // Only configured, good slots update; going offline gates all
            slotUpdateEnable <= goOffline ? {SLOTS{1'b0}} : (expected & ~badSlot);
            mismatchMap <= wrongType;
            faultMap <= badSlot | (expected & failSync);
            diagChanged <= (mismatchMap != wrongType) ||
                           (faultMap != (badSlot | (expected & failSync)));
        end
    end

    // ----------------------------------------------------------------
    // Diagnostic frame
    // ----------------------------------------------------------------
    function [7:0] diagAt;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: diagAt = {ctrl[`BMD_CTRL_OTHER_MASTER], ctrl[`BMD_CTRL_PARAM_ERR], 1'b0,
                                ctrl[`BMD_CTRL_UNSUP], 1'b1, anyBad & !ignoreOn,
                                !online, 1'b0};
                4'h1: diagAt = {1'b0, 1'b0, ctrl[`BMD_CTRL_SYNC], ctrl[`BMD_CTRL_FREEZE],
                                1'b0, 1'b1, 1'b0, !ctrl[`BMD_CTRL_PARAM_DONE]};
                4'h2: diagAt = 8'h00;
                4'h3: diagAt = ctrl[`BMD_CTRL_PARAM_DONE] ? masterAddr : `BMD_NO_MASTER;
                4'h4: diagAt = IDENT[15:8];
                4'h5: diagAt = IDENT[7:0];
                4'h6: diagAt = `BMD_HDR_DEVICE;
                4'h7: diagAt = {7'h00, ctrl[`BMD_CTRL_REMOTE_REQ]};
                4'ha: diagAt = mismatchMap[7:0];
                4'hb: diagAt = mismatchMap[15:8];
                4'hc: diagAt = `BMD_HDR_IDENT;
                4'hd: diagAt = faultMap[7:0];
                4'he: diagAt = faultMap[15:8];
                default: diagAt = 8'h00;
            endcase
        end
    endfunction

    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;
    reg state;
    reg [3:0] sendIdx;

    // Snapshot is not taken; bytes reflect live maps during the 15 cycles
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            sendIdx <= 4'h0;
            diagValid <= 1'b0;
            diagByte <= 8'h00;
            diagLast <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    diagValid <= 1'b0;
                    diagLast <= 1'b0;
                    if (readSync && !readSyncD)
                    begin
                        state <= ST_SEND;
                        sendIdx <= 4'h0;
                    end
                end
                ST_SEND:
                begin
                    diagValid <= 1'b1;
                    diagByte <= diagAt(sendIdx);
                    diagLast <= (sendIdx == `BMD_DIAG_LEN - 4'h1);
                    if (sendIdx == `BMD_DIAG_LEN - 4'h1)
                        state <= ST_IDLE;
                    else
                        sendIdx <= sendIdx + 4'h1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            regRdData <= 16'h0000;
        else if (regRead)
        begin
            case (regAddr)
                `BMD_REG_CTRL: regRdData <= ctrl;
                `BMD_REG_EXPECT: regRdData <= expected;
                `BMD_REG_STATUS: regRdData <= {9'h000, online, displayPoint, 1'b0, displayCode};
                `BMD_REG_DIAG_IDX: regRdData <= {12'h000, diagIdx};
                `BMD_REG_DIAG_DATA: regRdData <= {8'h00, diagAt(diagIdx)};
                `BMD_REG_MISMATCH: regRdData <= mismatchMap;
                `BMD_REG_FAULT: regRdData <= faultMap;
                `BMD_REG_MASTER: regRdData <= {8'h00, masterAddr};
                default: regRdData <= 16'h0000;
            endcase
        end
    end

endmodule // bmd_base_mismatch_diag
`default_nettype wire

// ### hw/bmd_defs.vh
// Constants of the base mismatch supervisor and diagnostic builder
`ifndef BMD_DEFS_VH
`define BMD_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define BMD_REG_CTRL 4'h0
`define BMD_REG_EXPECT 4'h1
`define BMD_REG_STATUS 4'h2
`define BMD_REG_DIAG_IDX 4'h3
`define BMD_REG_DIAG_DATA 4'h4
`define BMD_REG_MISMATCH 4'h5
`define BMD_REG_FAULT 4'h6
`define BMD_REG_MASTER 4'h7

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define BMD_CTRL_IGNORE 0
`define BMD_CTRL_RUN 1
`define BMD_CTRL_SYNC 2
`define BMD_CTRL_FREEZE 3
`define BMD_CTRL_PARAM_DONE 4
`define BMD_CTRL_PARAM_ERR 5
`define BMD_CTRL_OTHER_MASTER 6
`define BMD_CTRL_UNSUP 7
`define BMD_CTRL_REMOTE_REQ 8
`define BMD_CTRL_WRONG_POS 9
`define BMD_CTRL_RESET 16'h0000

// ----------------------------------------------------------------
// Display codes
// ----------------------------------------------------------------
`define BMD_DISP_OK 4'h0
`define BMD_DISP_REMOVED 4'h2
`define BMD_DISP_STOPPED 4'h3
`define BMD_DISP_WRONG_TYPE 4'ha
`define BMD_DISP_WRONG_POS 4'hb

// ----------------------------------------------------------------
// Diagnostic frame
// ----------------------------------------------------------------
`define BMD_DIAG_LEN 4'hf
`define BMD_NO_MASTER 8'hff
`define BMD_HDR_DEVICE 8'h06
`define BMD_HDR_IDENT 8'h43
// Arbitrary neutral identification value
`define BMD_IDENT_DEFAULT 16'h5a3c

`endif

// ### verif/bmd_diag_props.sv
// Checker of display, output policy and diagnostic frame
`default_nettype none
module bmd_diag_props #(
    parameter [15:0] IDENT = 16'h0000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic diagValid,
    input wire logic [7:0] diagByte,
    input wire logic diagLast,
    input wire logic [3:0] displayCode,
    input wire logic displayPoint,
    input wire logic online,
    input wire logic outputsFreeze,
    input wire logic outputsOff,
    input wire logic inputsForcedOff,
    input wire logic commLossOutputJumperFitted,
    input wire logic commLossOutputJumperFreeze
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Frame steps
    // ----------------------------------------
    sequence sStart;
        $rose(diagValid);
    endsequence
    sequence sBody;
        (diagValid && !diagLast)[*7] ##1 (diagValid && !diagLast)[*7];
    endsequence
    AST_FRAME_LEN: assert property (
        sStart |-> sBody ##1 (diagValid && diagLast) ##1 !diagValid)
        else $error("frame length wrong");
    AST_BYTE1: assert property (sStart |-> !diagByte[5] && diagByte[3])
        else $error("byte 1 fixed bits wrong");
    AST_BYTE2_3: assert property (
        sStart |-> ##1 diagByte[2:0] ==? 3'b10? && !diagByte[7] ##1 !diagByte[7])
        else $error("byte 2 or 3 fixed bits wrong");
    AST_IDENT: assert property (
        sStart |-> ##4 diagByte == IDENT[15:8] ##1 diagByte == IDENT[7:0])
        else $error("ident bytes wrong");
    AST_HDRS: assert property (
        sStart |-> ##6 diagByte == 8'h06 ##6 diagByte == 8'h43)
        else $error("header bytes wrong");
    AST_STOP: assert property (displayCode == 4'h3 |-> inputsForcedOff && !online)
        else $error("stopped bus keeps inputs");
    AST_ONLINE: assert property (
        online |-> !outputsOff && !outputsFreeze &&
        (displayCode == 4'h0 || (displayCode == 4'h2 && displayPoint)))
        else $error("online with mismatch state");
    AST_POLICY: assert property (!online |-> outputsOff != outputsFreeze)
        else $error("offline without one output policy");
    // Jumper pins reach the policy through two sync stages and one register
    AST_FREEZE: assert property (
        outputsFreeze |-> $past(commLossOutputJumperFitted, 3) &&
        $past(commLossOutputJumperFreeze, 3))
        else $error("freeze without jumper");
    AST_POINT: assert property (
        displayPoint |-> displayCode == 4'h0 || displayCode == 4'h2)
        else $error("point on wrong code");
endmodule // bmd_diag_props
bind bmd_base_mismatch_diag bmd_diag_props #(.IDENT(IDENT)) bmd_diag_props_inst (
    .ref_clk(ref_clk), .rst(rst), .diagValid(diagValid), .diagByte(diagByte),
    .diagLast(diagLast), .displayCode(displayCode), .displayPoint(displayPoint),
    .online(online), .outputsFreeze(outputsFreeze), .outputsOff(outputsOff),
    .inputsForcedOff(inputsForcedOff), .commLossOutputJumperFitted(commLossOutputJumperFitted),
    .commLossOutputJumperFreeze(commLossOutputJumperFreeze));
`default_nettype wire

// ### verif/bmd_master_model.sv
// Fieldbus master model: diagnostic reads and per-slave bookkeeping
`default_nettype none
module bmd_master_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic diagValid,
    input wire logic [7:0] diagByte,
    input wire logic diagLast,
    input wire logic online,
    input wire logic diagChanged,
    output logic diagReadReq,
    output logic done,
    output logic [7:0] frm [0:14]
);
    logic [3:0] idx;
    logic [15:0] noRespCount;
    logic faultBit;
    logic pendingDiag;
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            diagReadReq <= 1'b0;
            done <= 1'b0;
            idx <= 4'h0;
            noRespCount <= 16'h0000;
            faultBit <= 1'b1;
            pendingDiag <= 1'b0;
        end
        else
        begin
            faultBit <= !online;
            if (!online)
                noRespCount <= noRespCount + 16'h0001;
            // Read clears pending, a change sets it again
            if (diagChanged)
                pendingDiag <= 1'b1;
            else if (diagLast)
                pendingDiag <= 1'b0;
            if (start)
            begin
                diagReadReq <= 1'b1;
                done <= 1'b0;
                idx <= 4'h0;
            end
            if (diagValid)
            begin
                frm[idx] <= diagByte;
                idx <= idx + 4'h1;
            end
            if (diagLast)
            begin
                diagReadReq <= 1'b0;
                done <= 1'b1;
            end
        end
    end
endmodule // bmd_master_model
`default_nettype wire

// ### verif/bmd_base_mismatch_diag_bench.sv
// Self-checking bench of the base mismatch supervisor
`default_nettype none
`include "bmd_defs.vh"
module bmd_base_mismatch_diag_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] slotFitted = 16'h0000;
    logic [15:0] slotTypeOk = 16'hffff;
    logic [15:0] slotFailed = 16'h0000;
    logic jFit = 1'b0;
    logic jFrz = 1'b0;
    logic start = 1'b0;
    logic diagReadReq, diagValid, diagLast, done, displayPoint, online;
    logic outputsFreeze, outputsOff, inputsForcedOff, diagChanged;
    logic [15:0] regRdData, slotUpdateEnable;
    logic [7:0] diagByte;
    logic [3:0] displayCode;
    logic [7:0] frm [0:14];
    logic [7:0] expB [0:14];
    logic [7:0] mskB [0:14];
    int fail_count = 0;
    int n_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    bmd_base_mismatch_diag bmd_base_mismatch_diag_inst (.ref_clk(ref_clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .slotFitted(slotFitted), .slotTypeOk(slotTypeOk),
        .slotFailed(slotFailed), .commLossOutputJumperFitted(jFit),
        .commLossOutputJumperFreeze(jFrz), .diagReadReq(diagReadReq), .diagValid(diagValid),
        .diagByte(diagByte), .diagLast(diagLast), .displayCode(displayCode),
        .displayPoint(displayPoint), .online(online), .outputsFreeze(outputsFreeze),
        .outputsOff(outputsOff), .inputsForcedOff(inputsForcedOff),
        .slotUpdateEnable(slotUpdateEnable), .diagChanged(diagChanged));
    bmd_master_model bmd_master_model_inst (.ref_clk(ref_clk), .rst(rst), .start(start),
        .diagValid(diagValid), .diagByte(diagByte), .diagLast(diagLast), .online(online),
        .diagChanged(diagChanged), .diagReadReq(diagReadReq), .done(done), .frm(frm));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic wrap_up;
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 chk(regRdData, e);
    endtask
    // Pins pass a two-stage synchroniser, so allow it to settle
    task automatic slots(input logic [15:0] f, input logic [15:0] k, input logic [15:0] x);
        @(posedge ref_clk);
        slotFitted <= f;
        slotTypeOk <= k;
        slotFailed <= x;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic frame;
        int i;
        @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        for (i = 0; i < 60 && done !== 1'b1; i++)
            @(posedge ref_clk);
        #1;
        if (done !== 1'b1)
        begin
            fail_count++;
            wrap_up;
        end
        else
        begin
            for (i = 0; i < 15; i++)
                chk({8'h00, frm[i] & mskB[i]}, {8'h00, expB[i]});
        end
    endtask
    initial
    begin
        for (int i = 0; i < 15; i++)
            mskB[i] = 8'hff;
        mskB[0] = 8'hf8;
        mskB[1] = 8'hb6;
        mskB[2] = 8'h80;
        mskB[7] = 8'h01;
        mskB[8] = 8'h00;
        mskB[9] = 8'h00;
        expB = '{8'h08, 8'h34, 8'h00, 8'hff, 8'(`BMD_IDENT_DEFAULT >> 8),
            8'(`BMD_IDENT_DEFAULT), 8'h06, 8'h01, 8'h00, 8'h00, 8'h04, 8'h00, 8'h43,
            8'h06, 8'h00};
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`BMD_REG_STATUS, 16'h0003);
        chk({15'h0000, inputsForcedOff}, 16'h0001);
        rd(4'h9, 16'h0000);
        wr(`BMD_REG_EXPECT, 16'h000f);
        wr(`BMD_REG_CTRL, 16'h0002);
        slots(16'h000f, 16'hffff, 16'h0000);
        rd(`BMD_REG_STATUS, 16'h0040);
        slots(16'h001f, 16'hffff, 16'h0000);
        rd(`BMD_REG_STATUS, 16'h0040);
        slots(16'h000e, 16'hffff, 16'h0000);
        rd(`BMD_REG_STATUS, 16'h0002);
        chk({15'h0000, outputsOff}, 16'h0001);
        chk({15'h0000, bmd_master_model_inst.faultBit}, 16'h0001);
        @(posedge ref_clk);
        jFit <= 1'b1;
        jFrz <= 1'b1;
        slots(16'h000f, 16'hfffb, 16'h0000);
        rd(`BMD_REG_STATUS, 16'h000a);
        chk({15'h0000, outputsFreeze}, 16'h0001);
        rd(`BMD_REG_MISMATCH, 16'h0004);
        chk(slotUpdateEnable, 16'h0000);
        wr(`BMD_REG_CTRL, 16'h010e);
        slots(16'h000f, 16'hfffb, 16'h0002);
        rd(`BMD_REG_FAULT, 16'h0006);
        chk({15'h0000, bmd_master_model_inst.pendingDiag}, 16'h0001);
        frame();
        chk({15'h0000, bmd_master_model_inst.pendingDiag}, 16'h0000);
        chk({15'h0000, |bmd_master_model_inst.noRespCount}, 16'h0001);
        wr(`BMD_REG_DIAG_IDX, 16'h0006);
        rd(`BMD_REG_DIAG_DATA, 16'h0006);
        wr(`BMD_REG_CTRL, 16'h0003);
        slots(16'h001f, 16'hffff, 16'h0000);
        rd(`BMD_REG_STATUS, 16'h0060);
        slots(16'h000f, 16'hfffb, 16'h0000);
        rd(`BMD_REG_STATUS, 16'h0062);
        chk(slotUpdateEnable, 16'h000b);
        wr(`BMD_REG_CTRL, 16'h0202);
        chk({12'h000, displayCode}, 16'h000b);
        wr(`BMD_REG_MASTER, 16'h0005);
        rd(`BMD_REG_MASTER, 16'h0005);
        // Param done plus other master, param error and unsupported flags
        wr(`BMD_REG_CTRL, 16'h00f2);
        slots(16'h000f, 16'hffff, 16'h0000);
        expB[0] = 8'hd8;
        expB[1] = 8'h04;
        expB[3] = 8'h05;
        expB[7] = 8'h00;
        expB[10] = 8'h00;
        expB[13] = 8'h00;
        frame();
        wr(`BMD_REG_CTRL, 16'h0000);
        chk({12'h000, displayCode}, 16'h0003);
        wrap_up;
    end
endmodule // bmd_base_mismatch_diag_bench
`default_nettype wire
